// file: shared/acs_pkg.sv
`default_nettype none
package acs_pkg;
    // Register byte addresses (chosen)
    localparam logic [7:0] ADDR_CONV_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_SC_TWO = 8'h04;
    localparam logic [7:0] ADDR_SC_ONE = 8'h08;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h10;
    localparam logic [7:0] ADDR_CMP_HIGH = 8'h14;
    localparam logic [7:0] ADDR_CMP_LOW = 8'h18;
    localparam logic [7:0] ADDR_PIN_CTRL_ONE = 8'h1C;
    localparam logic [7:0] ADDR_PIN_CTRL_TWO = 8'h20;
    localparam logic [7:0] ADDR_POWER_CTRL = 8'h24;
    localparam int ADDR_SLOTS = 10;
    // Field positions
    localparam int CFG_LOW_POWER_BIT = 7;
    localparam int CFG_DIV_LSB = 5;
    localparam int CFG_LONG_SAMPLE_BIT = 4;
    localparam int CFG_RES_LSB = 2;
    localparam int CFG_CLK_LSB = 0;
    localparam int SC2_ACTIVE_BIT = 7;
    localparam int SC2_TRIG_BIT = 6;
    localparam int SC2_CMP_EN_BIT = 5;
    localparam int SC2_CMP_GT_BIT = 4;
    localparam int SC1_COMPLETE_BIT = 7;
    localparam int SC1_IRQ_EN_BIT = 6;
    localparam int SC1_CONT_BIT = 5;
    localparam int SC1_CHAN_LSB = 0;
    localparam int PWR_STOP3_BIT = 0;
    localparam int PWR_STOP2_BIT = 1;
    // Codes
    localparam logic [1:0] CLK_SEL_BUS = 2'h0;
    localparam logic [1:0] CLK_SEL_ASYNC = 2'h3;
    localparam logic [1:0] DIV_BY_ONE = 2'h0;
    localparam logic [1:0] RES_TEN_BIT = 2'h2;
    localparam logic [1:0] RES_EIGHT_BIT = 2'h0;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [4:0] RST_CHANNEL = 5'h1F;
    // Masks
    localparam logic [7:0] SC2_WRITE_MASK = 8'h73;
    // Conversion length in clock cycles (behavioural model of the SAR)
    localparam logic [5:0] CONV_CYCLES_SHORT = 6'h17;
    localparam logic [5:0] CONV_CYCLES_LONG = 6'h2B;
    typedef enum logic [1:0] {HTRANS_IDLE, HTRANS_BUSY, HTRANS_NONSEQ,
        HTRANS_SEQ} acs_htrans_t;
endpackage
`default_nettype wire

// file: shared/acs_conv_if.sv
`timescale 1ns/100ps
`default_nettype none
interface acs_conv_if;
    logic start;
    logic abort;
    logic long_sample;
    logic [11:0] sample;
    logic busy;
    logic done;
    logic [11:0] data;
    modport ctrl (output start, abort, long_sample, sample,
        input busy, done, data);
    modport sar (input start, abort, long_sample, sample,
        output busy, done, data);
endinterface
`default_nettype wire

// file: logic/acs_sar_engine.sv
`timescale 1ns/100ps
`default_nettype none
module acs_sar_engine
    import acs_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    acs_conv_if.sar conv
);
    logic [5:0] cnt_q;
    logic busy_q;
    logic done_q;
    logic [11:0] data_q;
    logic [11:0] held_q;
    wire [5:0] length = conv.long_sample ? CONV_CYCLES_LONG
                                         : CONV_CYCLES_SHORT;
    wire last = busy_q && (cnt_q == 6'h01);

    assign conv.busy = busy_q;
    assign conv.done = done_q;
    assign conv.data = data_q;

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q <= 6'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            data_q <= 12'h000;
            held_q <= 12'h000;
        end
        else
        begin
            done_q <= last && !conv.abort && !conv.start;
            if (conv.start)
            begin
                busy_q <= 1'b1;
                cnt_q <= length;
                held_q <= conv.sample;
            end
            else if (conv.abort)
                busy_q <= 1'b0;
            else if (busy_q)
            begin
                cnt_q <= cnt_q - 6'h01;
                if (last)
                begin
                    busy_q <= 1'b0;
                    data_q <= held_q;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: logic/acs_converter_ctrl.sv
// Operation
// [R1] Bus clock selected: entering stop3 aborts conversion and idles.
// [R2] Result bytes are kept through stop3 entry and exit.
// [R3] After an aborted stop3 the converter waits for a new trigger.
// [R4] Async clock selected: converter keeps running in stop3.
// [R5] Async clock: a running conversion completes normally in stop3.
// [R6] In stop3 with async clock, hardware trigger or continuous starts.
// [R7] Completion sets the flag; with enable set, raises wake output.
// [R8] Software clears read blocking before stop3 with conversions running.
// [R9] Stop2 disables the converter and resets all registers.
// [R10] After stop2 software re-enables and rewrites the configuration.
// [R11] Software writes config, then control two, then control one.
// [R12] Config layout: low power 7, divider 6:5, long 4, res 3:2, clk 1:0.
// [R13] Divider 00 is divide by one, res 10 is 10-bit, clk 00 bus.
// [R14] Control two: active 7, trigger 6, compare enable 5, greater 4.
// [R15] Control two bits 3:2 read zero; software writes zero to 1:0.
// [R16] Control one: complete 7, irq enable 6, continuous 5, channel 4:0.
// [R17] High byte read blocks result overwrite until low byte read.
// [R18] Pin control bit set disables digital I/O on that input.
// [R19] Compare value pair supplies threshold when compare is enabled.
// [R20] A failed compare sets no flag and leaves results untouched.
// [R21] Software trigger: control one write starts a new conversion.
`timescale 1ns/100ps
`default_nettype none
module acs_converter_ctrl
    import acs_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic [11:0] i_analog_sample,
    input wire logic i_hw_trigger,
    output logic [15:0] o_pin_io_disable,
    output logic [4:0] o_channel_select,
    output logic o_irq_wake,
    output logic o_converter_enabled
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] trig_sync_q;
    logic trig_prev_q;
    wire trig_edge = trig_sync_q[1] && !trig_prev_q;
    // Level settles through two flops; the engine takes it only at a start
    logic [11:0] level_meta_q;
    logic [11:0] level_sync_q;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] cfg_q;
    logic [7:0] sc2_q;
    logic [7:0] sc1_q;
    logic complete_q;
    logic [7:0] res_hi_q;
    logic [7:0] res_lo_q;
    logic [7:0] cmp_hi_q;
    logic [7:0] cmp_lo_q;
    logic [7:0] pin1_q;
    logic [7:0] pin2_q;
    logic stop3_q;
    logic stop2_q;
    logic block_q;
    logic [31:0] rdata_q;
    logic irq_q;
    logic en_q;

    // ------------------------------------------------------------
    // Bus address phase capture
    // ------------------------------------------------------------
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    wire addr_phase = i_hsel && i_hready && i_htrans[1];
    wire rd_take = addr_phase && !i_hwrite;
    wire [7:0] a = i_haddr[7:0];
    wire wr_cfg = wr_pend_q && (wr_addr_q == ADDR_CONV_CONFIG);
    wire wr_sc2 = wr_pend_q && (wr_addr_q == ADDR_SC_TWO);
    wire wr_sc1 = wr_pend_q && (wr_addr_q == ADDR_SC_ONE);
    wire wr_cmph = wr_pend_q && (wr_addr_q == ADDR_CMP_HIGH);
    wire wr_cmpl = wr_pend_q && (wr_addr_q == ADDR_CMP_LOW);
    wire wr_pin1 = wr_pend_q && (wr_addr_q == ADDR_PIN_CTRL_ONE);
    wire wr_pin2 = wr_pend_q && (wr_addr_q == ADDR_PIN_CTRL_TWO);
    wire wr_pwr = wr_pend_q && (wr_addr_q == ADDR_POWER_CTRL);
    wire rd_hi = rd_take && (a == ADDR_RESULT_HIGH);
    wire rd_lo = rd_take && (a == ADDR_RESULT_LOW);
    wire [7:0] wd = i_hwdata[7:0];

    // ------------------------------------------------------------
    // Conversion control
    // ------------------------------------------------------------
    acs_conv_if conv ();

    wire async_clk = cfg_q[CFG_CLK_LSB +: 2] == CLK_SEL_ASYNC;
    wire hw_trig_mode = sc2_q[SC2_TRIG_BIT];
    wire cont_mode = sc1_q[SC1_CONT_BIT];
    wire stop3_enter = wr_pwr && wd[PWR_STOP3_BIT] && !stop3_q;
    wire stop2_enter = wr_pwr && wd[PWR_STOP2_BIT];
    wire halted = stop3_q && !async_clk; // [R4]
    // Abort on stop3 entry only when the bus clock would vanish
    wire abort_stop3 = stop3_enter && !async_clk; // [R1]
    wire sw_start = wr_sc1 && !hw_trig_mode && !stop2_q; // [R21]
    wire hw_start = trig_edge && hw_trig_mode && !halted
                    && !stop2_q && !conv.busy; // [R6]
    wire cont_start = cont_mode && conv.done && !halted && !stop2_q; // [R6]

    // Compare and result forming
    wire [9:0] cmp_val = {cmp_hi_q[1:0], cmp_lo_q};
    wire [9:0] conv_res = conv.data[9:0];
    wire [10:0] diff = {1'b0, conv_res} - {1'b0, cmp_val};
    wire cmp_gt = sc2_q[SC2_CMP_GT_BIT];
    wire cmp_pass = cmp_gt ? !diff[10] : diff[10]; // [R19]
    wire cmp_on = sc2_q[SC2_CMP_EN_BIT];
    wire accept = conv.done && (!cmp_on || cmp_pass); // [R20]
    wire [9:0] store_val = cmp_on ? diff[9:0] : conv_res;
    wire [1:0] res_mode = cfg_q[CFG_RES_LSB +: 2];
    wire [7:0] new_hi = (res_mode == RES_EIGHT_BIT) ? 8'h00
                        : {6'h00, store_val[9:8]}; // [R13]
    wire [7:0] new_lo = store_val[7:0];

    assign conv.start = sw_start || hw_start || cont_start;
    assign conv.abort = abort_stop3 || stop2_enter || wr_sc1;
    assign conv.long_sample = cfg_q[CFG_LONG_SAMPLE_BIT]; // [R12]
    assign conv.sample = level_sync_q;

    acs_sar_engine u_sar (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .conv(conv)
    );

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire [7:0] sc2_rd = {conv.busy, sc2_q[6:4], 2'h0, sc2_q[1:0]}; // [R14] [R15]
    wire [7:0] sc1_rd = {complete_q, sc1_q[6:0]}; // [R16]
    logic [7:0] rd_byte;
    always_comb
    begin
        unique case (a)
            ADDR_CONV_CONFIG: rd_byte = cfg_q;
            ADDR_SC_TWO: rd_byte = sc2_rd;
            ADDR_SC_ONE: rd_byte = sc1_rd;
            ADDR_RESULT_HIGH: rd_byte = res_hi_q;
            ADDR_RESULT_LOW: rd_byte = res_lo_q;
            ADDR_CMP_HIGH: rd_byte = cmp_hi_q;
            ADDR_CMP_LOW: rd_byte = cmp_lo_q;
            ADDR_PIN_CTRL_ONE: rd_byte = pin1_q;
            ADDR_PIN_CTRL_TWO: rd_byte = pin2_q;
            ADDR_POWER_CTRL: rd_byte = {6'h00, stop2_q, stop3_q};
            default: rd_byte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Sequential logic
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            trig_sync_q <= 2'h0;
            trig_prev_q <= 1'b0;
            level_meta_q <= 12'h000;
            level_sync_q <= 12'h000;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            trig_sync_q <= {trig_sync_q[0], i_hw_trigger};
            trig_prev_q <= trig_sync_q[1];
            level_meta_q <= i_analog_sample;
            level_sync_q <= level_meta_q;
            wr_pend_q <= addr_phase && i_hwrite;
            wr_addr_q <= a;
            rdata_q <= rd_take ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Stop2 forces every register except the stop2 bit back to reset while asserted
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cfg_q <= RST_BYTE;
            sc2_q <= RST_BYTE;
            sc1_q <= {3'h0, RST_CHANNEL};
            cmp_hi_q <= RST_BYTE;
            cmp_lo_q <= RST_BYTE;
            pin1_q <= RST_BYTE;
            pin2_q <= RST_BYTE;
            stop3_q <= 1'b0;
            stop2_q <= 1'b0;
            en_q <= 1'b0;
        end
        else if (stop2_enter || (stop2_q && !wr_pwr))
        begin
            cfg_q <= RST_BYTE; // [R9]
            sc2_q <= RST_BYTE;
            sc1_q <= {3'h0, RST_CHANNEL};
            cmp_hi_q <= RST_BYTE;
            cmp_lo_q <= RST_BYTE;
            pin1_q <= RST_BYTE;
            pin2_q <= RST_BYTE;
            stop3_q <= 1'b0;
            stop2_q <= 1'b1;
            en_q <= 1'b0;
        end
        else
        begin
            if (wr_cfg)
                cfg_q <= wd; // [R12]
            if (wr_sc2)
                sc2_q <= wd & SC2_WRITE_MASK; // [R14]
            if (wr_sc1)
                sc1_q <= {1'b0, wd[6:0]}; // [R16]
            if (wr_cmph)
                cmp_hi_q <= {6'h00, wd[1:0]}; // [R19]
            if (wr_cmpl)
                cmp_lo_q <= wd;
            if (wr_pin1)
                pin1_q <= wd; // [R18]
            if (wr_pin2)
                pin2_q <= wd;
            if (wr_pwr)
            begin
                stop3_q <= wd[PWR_STOP3_BIT];
                stop2_q <= 1'b0;
            end
            // Enabled again only by a control one write after stop2
            if (wr_sc1)
                en_q <= 1'b1; // [R10]
        end
    end

    // Result and completion flag: kept across stop3, cleared on stop2
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            res_hi_q <= RST_BYTE;
            res_lo_q <= RST_BYTE;
            complete_q <= 1'b0;
            block_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else if (stop2_enter || stop2_q)
        begin
            res_hi_q <= RST_BYTE; // [R9]
            res_lo_q <= RST_BYTE;
            complete_q <= 1'b0;
            block_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            // Set beats the clear from a read or control one write
            if (accept && !block_q)
            begin
                res_hi_q <= new_hi; // [R2] [R5] [R20]
                res_lo_q <= new_lo;
                complete_q <= 1'b1; // [R7]
            end
            else if (wr_sc1 || rd_lo)
                complete_q <= 1'b0;
            // High byte read freezes the pair until the low byte is read or control one is written
            if (rd_hi)
                block_q <= 1'b1; // [R17]
            else if (rd_lo || wr_sc1)
                block_q <= 1'b0; // [R8]
            irq_q <= complete_q && sc1_q[SC1_IRQ_EN_BIT]; // [R7]
        end
    end

    // Idle after an aborted stop3 is implied: only triggers start it [R3]
    // Async clock keeps the engine counting through stop3 [R4]

    assign o_hrdata = rdata_q;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pin_io_disable <= 16'h0000;
            o_channel_select <= RST_CHANNEL;
            o_irq_wake <= 1'b0;
            o_converter_enabled <= 1'b0;
        end
        else
        begin
            o_pin_io_disable <= {pin2_q, pin1_q}; // [R18]
            o_channel_select <= sc1_q[SC1_CHAN_LSB +: 5];
            o_irq_wake <= irq_q;
            o_converter_enabled <= en_q; // [R9]
        end
    end
endmodule
`default_nettype wire

// file: bench/acs_converter_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module acs_converter_ctrl_sva
    import acs_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic [15:0] o_pin_io_disable,
    input wire logic [4:0] o_channel_select,
    input wire logic o_irq_wake,
    input wire logic o_converter_enabled
);
    // ----------------------------------------
    // Decoded address phases
    // ----------------------------------------
    wire logic take = i_hsel && i_hready && i_htrans[1];
    wire logic rd = take && !i_hwrite;
    wire logic wr = take && i_hwrite;
    wire logic wr_sc1 = wr && i_haddr[7:0] == ADDR_SC_ONE;
    wire logic wr_pin = wr && i_haddr[7:0] == ADDR_PIN_CTRL_ONE;
    wire logic wr_pwr = wr && i_haddr[7:0] == ADDR_POWER_CTRL;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    bus_okay_a: assert property (o_hreadyout && !o_hresp)
        else $error("bus not ready or error response");
    rdata_idle_a: assert property (!$past(rd) |-> o_hrdata == 32'h0)
        else $error("read data outside a read data phase");
    sc2_zero_a: assert property (
        rd && i_haddr[7:0] == ADDR_SC_TWO |=> o_hrdata[3:2] == 2'h0)
        else $error("control two bits 3:2 not zero");
    pin_disable_a: assert property (
        wr_pin |-> ##3 o_pin_io_disable[7:0] == $past(i_hwdata[7:0], 2))
        else $error("pin disable does not follow write");
    chan_select_a: assert property (
        wr_sc1 |-> ##3 o_channel_select == $past(i_hwdata[4:0], 2))
        else $error("channel does not follow write");
    enable_on_a: assert property (wr_sc1 |-> ##3 o_converter_enabled)
        else $error("converter not enabled by control one write");
    stop2_clear_a: assert property (
        wr_pwr ##1 i_hwdata[PWR_STOP2_BIT] |-> ##2 !o_converter_enabled &&
        o_channel_select == RST_CHANNEL && o_pin_io_disable == 16'h0000)
        else $error("stop2 did not restore reset state");
    wake_off_a: assert property (
        wr_sc1 ##1 !i_hwdata[SC1_IRQ_EN_BIT] |-> ##3 !o_irq_wake)
        else $error("wake raised with enable clear");
    cover property (wr_pwr ##1 i_hwdata[PWR_STOP2_BIT]);
    cover property ($rose(o_irq_wake));
    cover property (rd && i_haddr[7:0] == ADDR_RESULT_LOW);
endmodule
bind acs_converter_ctrl acs_converter_ctrl_sva chk
(
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_pin_io_disable(o_pin_io_disable),
    .o_channel_select(o_channel_select), .o_irq_wake(o_irq_wake),
    .o_converter_enabled(o_converter_enabled)
);
`default_nettype wire

// file: bench/acs_analog_pins.sv
`timescale 1ns/100ps
`default_nettype none
module acs_analog_pins
(
    input wire logic i_sys_clk,
    output logic [11:0] o_level,
    output logic o_trigger
);
    initial
    begin
        o_level = 12'h000;
        o_trigger = 1'b0;
    end
    // Level moves only on an edge, then settles through the pin flops
    task automatic set_level(input logic [11:0] v);
        @(posedge i_sys_clk);
        o_level <= v;
        repeat (2) @(posedge i_sys_clk);
    endtask
    // Held four cycles so the two-stage synchroniser cannot miss it
    task automatic pulse_trigger();
        @(posedge i_sys_clk);
        o_trigger <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        o_trigger <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: bench/adc_stop_mode_and_config_tb.sv
`timescale 1ns/100ps
`default_nettype none
module adc_stop_mode_and_config_tb
    import acs_pkg::*;
;
    logic clk;
    logic rst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [11:0] level;
    logic trig;
    logic [15:0] pin_off;
    logic [4:0] chan;
    logic wake;
    logic enabled;
    int fail_count;
    int cmp_count;
    always #2 clk = ~clk;
    acs_converter_ctrl dut
    (
        .i_sys_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .i_analog_sample(level),
        .i_hw_trigger(trig), .o_pin_io_disable(pin_off),
        .o_channel_select(chan), .o_irq_wake(wake),
        .o_converter_enabled(enabled)
    );
    acs_analog_pins pins
    (
        .i_sys_clk(clk), .o_level(level), .o_trigger(trig)
    );
    // ----------------------------------------
    // Bus and checking tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Waits for hready at each edge; a slave that never answers ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 50)
        begin
            fail_count++;
            $display("[FAIL] t=%0t hready got=%h exp=%h", $time, hready, 1'b1);
            report_and_stop();
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= w;
        wait_rdy();
        htrans <= HTRANS_IDLE;
        hwdata <= {24'h000000, d};
        wait_rdy();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rdm(input logic [7:0] a, input logic [7:0] m,
        input logic [7:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 8'h00, r);
        check(r & {24'h000000, m}, {24'h000000, e});
    endtask
    task automatic poll_done();
        logic [31:0] r;
        int n;
        n = 0;
        r = 32'h0;
        while (r[SC1_COMPLETE_BIT] !== 1'b1 && n < 60)
        begin
            xfer(1'b0, ADDR_SC_ONE, 8'h00, r);
            n++;
        end
        check({31'h0, r[SC1_COMPLETE_BIT]}, 32'h1);
        if (r[SC1_COMPLETE_BIT] !== 1'b1)
            report_and_stop();
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = HTRANS_IDLE;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fail_count = 0;
        cmp_count = 0;
        idle(2);
        rst <= 1'b0;
        rdm(ADDR_SC_ONE, 8'hFF, 8'h1F);
        rdm(8'h30, 8'hFF, 8'h00);
        wr(ADDR_CONV_CONFIG, 8'h98);
        rdm(ADDR_CONV_CONFIG, 8'hFF, 8'h98);
        wr(ADDR_SC_TWO, 8'h3C);
        rdm(ADDR_SC_TWO, 8'hFF, 8'h30);
        wr(ADDR_SC_TWO, 8'h00);
        wr(ADDR_PIN_CTRL_ONE, 8'h02);
        pins.set_level(12'h2A5);
        wr(ADDR_SC_ONE, 8'h41);
        poll_done();
        idle(3);
        check({16'h0, pin_off}, 32'h2);
        check({27'h0, chan}, 32'h1);
        check({31'h0, wake}, 32'h1);
        rdm(ADDR_RESULT_HIGH, 8'hFF, 8'h02);
        rdm(ADDR_RESULT_LOW, 8'hFF, 8'hA5);
        rdm(ADDR_SC_ONE, 8'h80, 8'h00);
        // Continuous mode: a high-byte read must freeze the pair
        wr(ADDR_SC_ONE, 8'h21);
        poll_done();
        rdm(ADDR_RESULT_HIGH, 8'hFF, 8'h02);
        pins.set_level(12'h155);
        idle(100);
        rdm(ADDR_RESULT_LOW, 8'hFF, 8'hA5);
        idle(100);
        rdm(ADDR_RESULT_HIGH, 8'hFF, 8'h01);
        rdm(ADDR_RESULT_LOW, 8'hFF, 8'h55);
        pins.set_level(12'h0F0);
        wr(ADDR_SC_ONE, 8'h01);
        wr(ADDR_POWER_CTRL, 8'h01);
        idle(100);
        rdm(ADDR_SC_ONE, 8'h80, 8'h00);
        rdm(ADDR_SC_TWO, 8'h80, 8'h00);
        rdm(ADDR_RESULT_HIGH, 8'hFF, 8'h01);
        rdm(ADDR_RESULT_LOW, 8'hFF, 8'h55);
        wr(ADDR_POWER_CTRL, 8'h00);
        idle(100);
        rdm(ADDR_SC_ONE, 8'h80, 8'h00);
        wr(ADDR_CONV_CONFIG, 8'h9B);
        wr(ADDR_SC_ONE, 8'h41);
        wr(ADDR_POWER_CTRL, 8'h01);
        poll_done();
        idle(3);
        check({31'h0, wake}, 32'h1);
        rdm(ADDR_RESULT_HIGH, 8'hFF, 8'h00);
        rdm(ADDR_RESULT_LOW, 8'hFF, 8'hF0);
        wr(ADDR_SC_TWO, 8'h40);
        pins.set_level(12'h3C3);
        pins.pulse_trigger();
        poll_done();
        rdm(ADDR_RESULT_HIGH, 8'hFF, 8'h03);
        rdm(ADDR_RESULT_LOW, 8'hFF, 8'hC3);
        wr(ADDR_POWER_CTRL, 8'h00);
        wr(ADDR_CONV_CONFIG, 8'h98);
        wr(ADDR_CMP_HIGH, 8'h00);
        wr(ADDR_CMP_LOW, 8'h10);
        wr(ADDR_SC_TWO, 8'h20);
        pins.set_level(12'h200);
        wr(ADDR_SC_ONE, 8'h01);
        idle(100);
        rdm(ADDR_SC_ONE, 8'h80, 8'h00);
        rdm(ADDR_RESULT_LOW, 8'hFF, 8'hC3);
        wr(ADDR_SC_TWO, 8'h30);
        wr(ADDR_SC_ONE, 8'h01);
        poll_done();
        rdm(ADDR_RESULT_HIGH, 8'hFF, 8'h01);
        rdm(ADDR_RESULT_LOW, 8'hFF, 8'hF0);
        wr(ADDR_POWER_CTRL, 8'h02);
        idle(2);
        check({31'h0, enabled}, 32'h0);
        check({16'h0, pin_off}, 32'h0);
        rdm(ADDR_CONV_CONFIG, 8'hFF, 8'h00);
        rdm(ADDR_SC_TWO, 8'hFF, 8'h00);
        rdm(ADDR_CMP_LOW, 8'hFF, 8'h00);
        rdm(ADDR_SC_ONE, 8'hFF, 8'h1F);
        wr(ADDR_POWER_CTRL, 8'h00);
        wr(ADDR_CONV_CONFIG, 8'h98);
        wr(ADDR_SC_TWO, 8'h00);
        wr(ADDR_SC_ONE, 8'h41);
        poll_done();
        check({31'h0, enabled}, 32'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
